// ===== common/pump_pkg.sv
// constants, register map and enumerations of the metering pump arbiter
package pump_pkg;
  // clock and time base
  localparam int CLK_NS    = 40;
  localparam int TICK_US   = 1000;
  localparam int TICK_CYC  = (TICK_US * 1000) / CLK_NS;
  localparam int PER_MIN   = 60000;
  // times in ms, counts in ms ticks
  localparam int PRIME_MS  = 5000;
  localparam int BLINK_MS  = 100;
  localparam int PACE_MS   = 100;
  localparam int FLASH_MS  = 500;
  localparam int PRIME_TK  = (PRIME_MS * 1000) / TICK_US;
  localparam int BLINK_TK  = (BLINK_MS * 1000) / TICK_US;
  localparam int PACE_TK   = (PACE_MS * 1000) / TICK_US;
  localparam int FLASH_TK  = (FLASH_MS * 1000) / TICK_US;
  // rates in strokes per minute
  localparam logic [7:0]  MAX_RATE = 8'hc8;
  // contact factor in hundredths, 0.01 .. 100.00
  localparam logic [13:0] FAC_MIN  = 14'h0001;
  localparam logic [13:0] FAC_MAX  = 14'h2710;
  localparam logic [23:0] UNIT     = 24'h000064;
  localparam logic [16:0] BATCH_MAX = 17'h1869f;
  // analog input code of 4 mA on a 20 mA, 10-bit scale
  localparam logic [9:0]  ANA_4MA  = 10'h0cd;
  localparam logic [12:0] ANA_GAIN = 13'h0005;
  // current output: 12-bit code, 4 mA offset, gains scaled by 256
  localparam logic [11:0] IOUT_4MA = 12'h333;
  localparam logic [12:0] IOUT_G0  = 13'h1479;
  localparam logic [12:0] IOUT_G4  = 13'h1061;
  // register word indices
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_MRATE  = 4'h1;
  localparam logic [3:0] A_ARATE  = 4'h2;
  localparam logic [3:0] A_FACTOR = 4'h3;
  localparam logic [3:0] A_BATCH  = 4'h4;
  localparam logic [3:0] A_FLIM   = 4'h5;
  localparam logic [3:0] A_ASEL   = 4'h6;
  localparam logic [3:0] A_STAT   = 4'h7;
  localparam logic [3:0] A_PEND   = 4'h8;
  localparam logic [3:0] A_CNT    = 4'h9;
  // control register fields
  localparam int C_MODE = 0;
  localparam int C_A420 = 2;
  localparam int C_AUX  = 3;
  localparam int C_OVL  = 4;
  localparam int C_FLOW = 5;
  localparam int C_IOUT = 6;
  localparam int C_I4MA = 7;
  localparam int C_CLR  = 8;
  // pin vector positions
  localparam int P_STOP = 0;
  localparam int P_UP   = 1;
  localparam int P_DN   = 2;
  localparam int P_PROG = 3;
  localparam int P_TRIG = 4;
  localparam int P_PAUS = 5;
  localparam int P_AUX  = 6;
  localparam int P_LV1  = 7;
  localparam int P_LV2  = 8;
  localparam int P_OVL  = 9;
  localparam int P_OK   = 10;
  localparam int P_MON  = 11;
  localparam int NPINS  = 12;
  typedef enum logic [1:0] {
    M_MANUAL  = 2'b00,
    M_ANALOG  = 2'b01,
    M_CONTACT = 2'b10,
    M_BATCH   = 2'b11
  } mode_t;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_PRIME = 3'b001,
    S_HALT  = 3'b010,
    S_AUX   = 3'b011,
    S_MODE  = 3'b100
  } src_t;
  typedef enum logic [1:0] {
    BUS_OP    = 2'b00,
    BUS_PRE   = 2'b01,
    BUS_ERR   = 2'b10
  } bus_t;
  localparam logic [3:0] E_NONE  = 4'h0;
  localparam logic [3:0] E_LEVEL = 4'h1;
  localparam logic [3:0] E_OVL   = 4'h2;
  localparam logic [3:0] E_FLOW  = 4'h3;
endpackage : pump_pkg

// ===== logic/pin_sync.sv
// two-stage synchroniser for the external pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_lvl
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } sync_t;
  sync_t s_q, s_d;

  // first stage feeds only the second
  always_comb begin
    s_d.meta = i_pin;
    s_d.safe = s_q.meta;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_lvl = s_q.safe;
endmodule : pin_sync
`default_nettype wire

// ===== logic/stroke_gen.sv
// ms tick and rate accumulator giving one stroke event per period
`timescale 1ns/1ps
`default_nettype none
module stroke_gen #(
  parameter int TICK_CYC = pump_pkg::TICK_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire logic [7:0] i_rate,
  output logic            o_tick,
  output logic            o_stroke
);
  localparam int PW = $clog2(TICK_CYC + 1);
  typedef struct packed {
    logic [PW-1:0] pre;
    logic [15:0]   acc;
    logic          tick;
    logic          stroke;
  } gen_t;
  gen_t g_q, g_d;

  // phase accumulator: rate added each ms, wraps once per stroke period
  always_comb begin
    logic [16:0] sum;
    sum = {1'b0, g_q.acc} + {9'h000, i_rate};
    g_d = g_q;
    g_d.tick = 1'b0;
    g_d.stroke = 1'b0;
    if (g_q.pre == PW'(TICK_CYC - 1)) begin
      g_d.pre = '0;
      g_d.tick = 1'b1;
      if (sum >= 17'(pump_pkg::PER_MIN)) begin
        g_d.acc = 16'(sum - 17'(pump_pkg::PER_MIN));
        g_d.stroke = 1'b1;
      end else begin
        g_d.acc = sum[15:0];
      end
    end else begin
      g_d.pre = g_q.pre + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      g_q <= '0;
    end else begin
      g_q <= g_d;
    end
  end

  assign o_tick = g_q.tick;
  assign o_stroke = g_q.stroke;
endmodule : stroke_gen
`default_nettype wire

// ===== logic/pump_arbiter.sv
// mode arbiter, fault logic, indicators and relays of the metering pump
// Notes on behaviour
// - manual mode uses operator rate only
// - analog mode scales input current, chosen type
// - contact pulse meters quantity times factor
// - program key or trigger starts batch
// - overload outside tolerance stops pump
// - selected auxiliary rate overrides mode rate
// - defective strokes reaching limit stop pump
// - level stage one lights warning
// - any fault lights fault indicator
// - pause only from external terminal halts
// - stop key toggles stopped and running
// - both arrows held prime at maximum
// - alarm relay on selected events
// - pacing relay closes once per stroke
// - current output follows metering rate
// - bus lamp steady, flashing or red
// - operating lamp dark briefly each stroke
// - priority prime, halt, auxiliary, mode
// - priming allowed in any mode if functional
// - stop, pause block all but priming; fault blocks priming too
// - fault shows error code on display
`timescale 1ns/1ps
`default_nettype none
module pump_arbiter #(
  parameter int TICK_CYC = pump_pkg::TICK_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_key_stop,
  input  wire logic        i_key_up,
  input  wire logic        i_key_down,
  input  wire logic        i_key_prog,
  input  wire logic        i_ext_trig,
  input  wire logic        i_ext_pause,
  input  wire logic        i_ext_aux,
  input  wire logic        i_level_low1,
  input  wire logic        i_level_low2,
  input  wire logic        i_overload,
  input  wire logic        i_flow_ok,
  input  wire logic        i_monitor_on,
  input  wire logic [9:0]  i_analog,
  input  wire logic [1:0]  i_bus_state,
  output logic [7:0]       o_rate,
  output logic             o_stroke,
  output logic             o_led_op,
  output logic             o_led_fault,
  output logic             o_led_warn,
  output logic             o_led_bus_g,
  output logic             o_led_bus_r,
  output logic             o_alarm,
  output logic             o_pace,
  output logic [11:0]      o_iout,
  output logic             o_err_show,
  output logic [3:0]       o_err_code
);
  typedef struct packed {
    logic [8:0]       ctrl;
    logic [7:0]       mrate;
    logic [7:0]       arate;
    logic [13:0]      factor;
    logic [16:0]      batch;
    logic [7:0]       flim;
    logic [3:0]       asel;
    logic [31:0]      rdata;
    logic [2:0]       prev;
    logic             stopped;
    logic             pdone;
    logic [12:0]      pcnt;
    logic [23:0]      pend;
    logic             ovl_f;
    logic             flow_f;
    logic [7:0]       defects;
    logic             ok_seen;
    logic             ok_prev;
    logic [7:0]       rate;
    pump_pkg::src_t   src;
    logic [6:0]       blink;
    logic [6:0]       pace;
    logic [8:0]       fcnt;
    logic             flash;
    logic [31:0]      strokes;
    logic             led_op;
    logic             led_fault;
    logic             led_warn;
    logic             bus_g;
    logic             bus_r;
    logic             alarm;
    logic             pace_o;
    logic [11:0]      iout;
    logic [3:0]       err;
  } st_t;
  st_t s_q, s_d;

  logic [pump_pkg::NPINS-1:0] pin;
  logic tick;
  logic stroke;

  pin_sync #(.W(pump_pkg::NPINS)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_pin     ({i_monitor_on, i_flow_ok, i_overload, i_level_low2,
                 i_level_low1, i_ext_aux, i_ext_pause, i_ext_trig,
                 i_key_prog, i_key_down, i_key_up, i_key_stop}),
    .o_lvl     (pin)
  );

  stroke_gen #(.TICK_CYC(TICK_CYC)) u_gen (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_rate    (s_q.rate),
    .o_tick    (tick),
    .o_stroke  (stroke)
  );

  // decoded conditions
  pump_pkg::mode_t mode;
  logic stop_e, prog_e, trig_e, ok_e;
  logic prime_req, fault, halt, aux_on, clr;
  logic [17:0] ana_p;
  logic [7:0]  ana_rate, mode_rate;
  logic [20:0] iout_p;
  logic [23:0] pend_add;

  always_comb begin
    mode = pump_pkg::mode_t'(s_q.ctrl[pump_pkg::C_MODE +: 2]);
    stop_e = pin[pump_pkg::P_STOP] & ~s_q.prev[0];
    prog_e = pin[pump_pkg::P_PROG] & ~s_q.prev[1];
    trig_e = pin[pump_pkg::P_TRIG] & ~s_q.prev[2];
    ok_e = pin[pump_pkg::P_OK] & ~s_q.ok_prev;
    clr = i_wr & (i_addr == pump_pkg::A_CTRL) & i_wdata[pump_pkg::C_CLR];
    prime_req = pin[pump_pkg::P_UP] & pin[pump_pkg::P_DN];
    fault = pin[pump_pkg::P_LV2] | s_q.ovl_f | s_q.flow_f;
    halt = fault | s_q.stopped | pin[pump_pkg::P_PAUS];
    aux_on = s_q.ctrl[pump_pkg::C_AUX] & pin[pump_pkg::P_AUX];
  end

  // mode-derived rate; analog codes scaled by shifts, not division
  always_comb begin
    ana_p = '0;
    if (s_q.ctrl[pump_pkg::C_A420]) begin
      // operands widened before the product, else the top bits fall off
      if (i_analog > pump_pkg::ANA_4MA) begin
        ana_p = 18'(i_analog - pump_pkg::ANA_4MA) * 18'(pump_pkg::MAX_RATE);
        ana_p = 18'((28'(ana_p) * 28'(pump_pkg::ANA_GAIN)) >> 12);
      end
    end else begin
      ana_p = 18'((28'(i_analog) * 28'(pump_pkg::MAX_RATE)) >> 10);
    end
    ana_rate = ana_p[7:0];
    case (mode)
      pump_pkg::M_MANUAL: mode_rate = s_q.mrate;
      pump_pkg::M_ANALOG: mode_rate = ana_rate;
      pump_pkg::M_CONTACT,
      pump_pkg::M_BATCH: mode_rate = (s_q.pend >= pump_pkg::UNIT) ? s_q.mrate : 8'h00;
      default: mode_rate = 8'h00;
    endcase
  end

  // contact adds factor in hundredths, batch loads whole strokes
  always_comb begin
    pend_add = '0;
    if (mode == pump_pkg::M_CONTACT && trig_e) begin
      pend_add = {10'h000, s_q.factor};
    end
    iout_p = '0;
    if (s_q.ctrl[pump_pkg::C_I4MA]) begin
      iout_p = 21'(s_d.rate) * 21'(pump_pkg::IOUT_G4);
    end else begin
      iout_p = 21'(s_d.rate) * 21'(pump_pkg::IOUT_G0);
    end
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.prev = {pin[pump_pkg::P_TRIG], pin[pump_pkg::P_PROG], pin[pump_pkg::P_STOP]};
    s_d.ok_prev = pin[pump_pkg::P_OK];
    // register writes
    if (i_wr) begin
      case (i_addr)
        pump_pkg::A_CTRL: s_d.ctrl = {1'b0, i_wdata[7:0]};
        pump_pkg::A_MRATE: s_d.mrate = (i_wdata[7:0] > pump_pkg::MAX_RATE) ?
                                       pump_pkg::MAX_RATE : i_wdata[7:0];
        pump_pkg::A_ARATE: s_d.arate = (i_wdata[7:0] > pump_pkg::MAX_RATE) ?
                                       pump_pkg::MAX_RATE : i_wdata[7:0];
        pump_pkg::A_FACTOR: begin
          if (i_wdata[13:0] < pump_pkg::FAC_MIN || i_wdata[31:14] != '0) begin
            s_d.factor = (i_wdata[31:14] != '0) ? pump_pkg::FAC_MAX : pump_pkg::FAC_MIN;
          end else if (i_wdata[13:0] > pump_pkg::FAC_MAX) begin
            s_d.factor = pump_pkg::FAC_MAX;
          end else begin
            s_d.factor = i_wdata[13:0];
          end
        end
        pump_pkg::A_BATCH: s_d.batch = (i_wdata[31:17] != '0 ||
                                        i_wdata[16:0] > pump_pkg::BATCH_MAX) ?
                                       pump_pkg::BATCH_MAX : i_wdata[16:0];
        pump_pkg::A_FLIM: s_d.flim = i_wdata[7:0];
        pump_pkg::A_ASEL: s_d.asel = i_wdata[3:0];
        default: ;
      endcase
    end
    // stop key toggles, power stays on
    s_d.stopped = s_q.stopped ^ stop_e;
    // priming runs for a limited time, re-armed on key release
    if (!prime_req) begin
      s_d.pdone = 1'b0;
      s_d.pcnt = '0;
    end else if (s_q.src == pump_pkg::S_PRIME && tick) begin
      s_d.pcnt = s_q.pcnt + 1'b1;
      if (s_q.pcnt == 13'(pump_pkg::PRIME_TK - 1)) begin
        s_d.pdone = 1'b1;
      end
    end
    // pending quantity in hundredths of a stroke
    s_d.pend = s_q.pend + pend_add;
    if (mode == pump_pkg::M_BATCH && (prog_e || trig_e) && s_q.pend < pump_pkg::UNIT) begin
      s_d.pend = 24'(s_q.batch * pump_pkg::UNIT);
    end else if (stroke && s_q.src == pump_pkg::S_MODE && s_q.pend >= pump_pkg::UNIT) begin
      s_d.pend = s_q.pend + pend_add - pump_pkg::UNIT;
    end
    if (mode == pump_pkg::M_MANUAL || mode == pump_pkg::M_ANALOG) begin
      s_d.pend = '0;
    end
    // overload latch, set wins over clear
    if (clr) begin
      s_d.ovl_f = 1'b0;
      s_d.flow_f = 1'b0;
      s_d.defects = '0;
    end
    if (s_q.ctrl[pump_pkg::C_OVL] && pin[pump_pkg::P_OVL]) begin
      s_d.ovl_f = 1'b1;
    end
    // a stroke with no monitor answer since the last one is defective
    s_d.ok_seen = ok_e | (s_q.ok_seen & ~stroke);
    if (s_q.ctrl[pump_pkg::C_FLOW] && pin[pump_pkg::P_MON] && stroke) begin
      if (!s_q.ok_seen && !ok_e) begin
        s_d.defects = s_q.defects + 1'b1;
        if (s_q.defects + 8'h01 >= s_q.flim) begin
          s_d.flow_f = 1'b1;
        end
      end else begin
        s_d.defects = '0;
      end
    end
    // rate arbitration by priority
    if (prime_req && !fault && !s_d.pdone) begin
      s_d.src = pump_pkg::S_PRIME;
    end else if (halt) begin
      s_d.src = pump_pkg::S_HALT;
    end else if (aux_on) begin
      s_d.src = pump_pkg::S_AUX;
    end else begin
      s_d.src = pump_pkg::S_MODE;
    end
    case (s_d.src)
      pump_pkg::S_PRIME: s_d.rate = pump_pkg::MAX_RATE;
      pump_pkg::S_HALT: s_d.rate = 8'h00;
      pump_pkg::S_AUX: s_d.rate = s_q.arate;
      pump_pkg::S_MODE: s_d.rate = mode_rate;
      default: s_d.rate = 8'h00;
    endcase
    // per-stroke timers and the bus lamp flash divider
    if (stroke) begin
      s_d.strokes = s_q.strokes + 1'b1;
      s_d.blink = 7'(pump_pkg::BLINK_TK);
      s_d.pace = 7'(pump_pkg::PACE_TK);
    end else if (tick) begin
      s_d.blink = (s_q.blink != '0) ? s_q.blink - 1'b1 : '0;
      s_d.pace = (s_q.pace != '0) ? s_q.pace - 1'b1 : '0;
    end
    if (tick) begin
      s_d.fcnt = s_q.fcnt + 1'b1;
      if (s_q.fcnt == 9'(pump_pkg::FLASH_TK - 1)) begin
        s_d.fcnt = '0;
        s_d.flash = ~s_q.flash;
      end
    end
    // indicators and relays
    s_d.led_op = (s_d.blink == '0);
    s_d.pace_o = (s_d.pace != '0);
    s_d.led_fault = fault;
    s_d.led_warn = pin[pump_pkg::P_LV1];
    s_d.alarm = |(s_q.asel & {pin[pump_pkg::P_LV1] | pin[pump_pkg::P_LV2],
                              s_q.stopped, pin[pump_pkg::P_LV1], fault});
    case (pump_pkg::bus_t'(i_bus_state))
      pump_pkg::BUS_OP: {s_d.bus_g, s_d.bus_r} = 2'b10;
      pump_pkg::BUS_PRE: {s_d.bus_g, s_d.bus_r} = {s_q.flash, 1'b0};
      default: {s_d.bus_g, s_d.bus_r} = 2'b01;
    endcase
    if (!s_q.ctrl[pump_pkg::C_IOUT]) begin
      s_d.iout = 12'h000;
    end else if (s_q.ctrl[pump_pkg::C_I4MA]) begin
      s_d.iout = pump_pkg::IOUT_4MA + iout_p[19:8];
    end else begin
      s_d.iout = iout_p[19:8];
    end
    // error identifier, level first
    if (pin[pump_pkg::P_LV2]) begin
      s_d.err = pump_pkg::E_LEVEL;
    end else if (s_q.ovl_f) begin
      s_d.err = pump_pkg::E_OVL;
    end else if (s_q.flow_f) begin
      s_d.err = pump_pkg::E_FLOW;
    end else begin
      s_d.err = pump_pkg::E_NONE;
    end
    // read data stands only in the cycle after the strobe
    s_d.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        pump_pkg::A_CTRL: s_d.rdata = {23'h0, s_q.ctrl};
        pump_pkg::A_MRATE: s_d.rdata = {24'h0, s_q.mrate};
        pump_pkg::A_ARATE: s_d.rdata = {24'h0, s_q.arate};
        pump_pkg::A_FACTOR: s_d.rdata = {18'h0, s_q.factor};
        pump_pkg::A_BATCH: s_d.rdata = {15'h0, s_q.batch};
        pump_pkg::A_FLIM: s_d.rdata = {24'h0, s_q.flim};
        pump_pkg::A_ASEL: s_d.rdata = {28'h0, s_q.asel};
        pump_pkg::A_STAT: s_d.rdata = {12'h0, s_q.defects, s_q.err, 1'b0, s_q.src,
                                       s_q.led_warn, fault, s_q.pdone, s_q.stopped};
        pump_pkg::A_PEND: s_d.rdata = {8'h0, s_q.pend};
        pump_pkg::A_CNT: s_d.rdata = s_q.strokes;
        default: s_d.rdata = '0;
      endcase
    end
  end

  // single state register; pump starts running with lamps off
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
      s_q.src <= pump_pkg::S_IDLE;
      s_q.factor <= pump_pkg::FAC_MIN;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_rate = s_q.rate;
  assign o_stroke = stroke;
  assign o_led_op = s_q.led_op;
  assign o_led_fault = s_q.led_fault;
  assign o_led_warn = s_q.led_warn;
  assign o_led_bus_g = s_q.bus_g;
  assign o_led_bus_r = s_q.bus_r;
  assign o_alarm = s_q.alarm;
  assign o_pace = s_q.pace_o;
  assign o_iout = s_q.iout;
  assign o_err_show = s_q.led_fault;
  assign o_err_code = s_q.err;

  // checks
  AST_HALT_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_q.src == pump_pkg::S_HALT |-> s_q.rate == 8'h00)
    else $error("halted pump has a nonzero rate");
  AST_PRIME_MAX: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_q.src == pump_pkg::S_PRIME |-> s_q.rate == pump_pkg::MAX_RATE)
    else $error("priming not at maximum rate");
  AST_PAUSE_HALT: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    pin[pump_pkg::P_PAUS] && !prime_req |=> s_q.src == pump_pkg::S_HALT)
    else $error("pause did not halt the pump");
  AST_STOP_TOGGLE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    stop_e |=> s_q.stopped != $past(s_q.stopped))
    else $error("stop key did not toggle");
  AST_PACE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    stroke |=> o_pace ##1 o_pace)
    else $error("pacing relay missed a stroke");
  AST_OP_BLINK: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    stroke |=> !o_led_op)
    else $error("operating lamp not dark after stroke");
  AST_FAULT_LED: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    pin[pump_pkg::P_LV2] |=> o_led_fault && o_err_code == pump_pkg::E_LEVEL)
    else $error("level fault not shown");
  AST_WARN_LED: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(pin[pump_pkg::P_LV1]) |=> o_led_warn)
    else $error("warning lamp not lit");
  AST_AUX_RATE: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    aux_on && !halt && !prime_req |=> o_rate == $past(s_q.arate))
    else $error("auxiliary rate not applied");
  AST_OVL_STOP: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_q.ctrl[pump_pkg::C_OVL] && pin[pump_pkg::P_OVL] && !prime_req
    |=> ##1 s_q.src == pump_pkg::S_HALT)
    else $error("overload did not stop the pump");
endmodule : pump_arbiter
`default_nettype wire

// ===== verif/pump_far_side.sv
// flow monitor model that answers each pump stroke that is not dry
`timescale 1ns/1ps
`default_nettype none
module pump_far_side (
  input  wire logic i_ref_clk,
  input  wire logic i_rstn,
  input  wire logic i_stroke,
  input  wire logic i_dry,
  output logic      o_flow_ok,
  output logic      o_monitor_on
);
  logic [3:0] dly_q;
  // answer a few cycles late, held 4 cycles so the pin synchroniser sees it
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dly_q <= 4'h0;
    end else if (i_stroke && !i_dry) begin
      dly_q <= 4'h8;
    end else if (dly_q != 4'h0) begin
      dly_q <= dly_q - 4'h1;
    end
  end
  // a dry stroke gets no answer at all, so the pump sees a defect
  assign o_flow_ok    = (dly_q > 4'h0) && (dly_q < 4'h5);
  assign o_monitor_on = 1'b1;
endmodule : pump_far_side
`default_nettype wire

// ===== verif/test_metering_pump_mode_arbiter.sv
// self-checking bench of the metering pump arbiter
`timescale 1ns/1ps
`default_nettype none
module test_metering_pump_mode_arbiter;
  localparam int TK = 10; // short ms tick keeps stroke periods short
  logic        i_ref_clk, i_rstn, i_wr, i_rd, dry, flow_ok, mon_on;
  logic [3:0]  i_addr, o_err_code;
  logic [31:0] i_wdata, o_rdata, rv;
  logic [9:0]  pins, i_analog;
  logic [1:0]  i_bus_state;
  logic [7:0]  o_rate;
  logic        o_stroke, o_led_op, o_led_fault, o_led_warn, o_led_bus_g, o_led_bus_r;
  logic        o_alarm, o_pace, o_err_show;
  logic [11:0] o_iout;
  int          n_mismatch = 0, samples_checked = 0, cycles = 0, n;
  pump_arbiter #(.TICK_CYC(TK)) uut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_key_stop(pins[pump_pkg::P_STOP]), .i_key_up(pins[pump_pkg::P_UP]),
    .i_key_down(pins[pump_pkg::P_DN]), .i_key_prog(pins[pump_pkg::P_PROG]),
    .i_ext_trig(pins[pump_pkg::P_TRIG]), .i_ext_pause(pins[pump_pkg::P_PAUS]),
    .i_ext_aux(pins[pump_pkg::P_AUX]), .i_level_low1(pins[pump_pkg::P_LV1]),
    .i_level_low2(pins[pump_pkg::P_LV2]), .i_overload(pins[pump_pkg::P_OVL]),
    .i_flow_ok(flow_ok), .i_monitor_on(mon_on), .i_analog(i_analog),
    .i_bus_state(i_bus_state), .o_rate(o_rate), .o_stroke(o_stroke), .o_led_op(o_led_op),
    .o_led_fault(o_led_fault), .o_led_warn(o_led_warn), .o_led_bus_g(o_led_bus_g),
    .o_led_bus_r(o_led_bus_r), .o_alarm(o_alarm), .o_pace(o_pace), .o_iout(o_iout),
    .o_err_show(o_err_show), .o_err_code(o_err_code));
  pump_far_side far (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_stroke(o_stroke),
    .i_dry(dry), .o_flow_ok(flow_ok), .o_monitor_on(mon_on));
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [3:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    rv = o_rdata;
  endtask : rd
  // pins pass two sync flops, so allow several edges before looking
  task automatic setp(input int idx, input logic v);
    @(posedge i_ref_clk);
    pins[idx] <= v;
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask : setp
  task automatic wstroke();
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (o_stroke !== 1'b1 && n < 4000);
  endtask : wstroke
  task automatic t_manual();
    rd(pump_pkg::A_FACTOR);
    chk("factor_rst", 32'h1, rv);
    chk("bus_green", 32'h1, 32'(o_led_bus_g));
    wr(pump_pkg::A_MRATE, 32'h32);
    setp(pump_pkg::P_UP, 1'b0);
    chk("rate_manual", 32'h32, 32'(o_rate));
    rd(4'hf);
    chk("unmapped", 32'h0, rv);
  endtask : t_manual
  task automatic t_stroke();
    wr(pump_pkg::A_MRATE, 32'hc8);
    wstroke();
    wstroke();
    chk("period", 32'h00000bb8, 32'(n));
    @(negedge i_ref_clk);
    chk("pace", 32'h1, 32'(o_pace));
    chk("op_lamp", 32'h0, 32'(o_led_op));
    wr(pump_pkg::A_FLIM, 32'h1);
    wr(pump_pkg::A_CTRL, 32'h20);
    dry <= 1'b1;
    // a stroke is judged at the next one, so two dry strokes are needed
    wstroke();
    wstroke();
    repeat (12) @(negedge i_ref_clk);
    chk("flow_code", 32'(pump_pkg::E_FLOW), 32'(o_err_code));
    chk("flow_lamp", 32'h1, 32'(o_led_fault));
    dry <= 1'b0;
    wr(pump_pkg::A_CTRL, 32'h100);
    setp(pump_pkg::P_UP, 1'b0);
    chk("flow_clr", 32'h0, 32'(o_err_code));
  endtask : t_stroke
  task automatic t_halt();
    wr(pump_pkg::A_CTRL, 32'h8);
    wr(pump_pkg::A_ARATE, 32'h1e);
    setp(pump_pkg::P_AUX, 1'b1);
    chk("rate_aux", 32'h1e, 32'(o_rate));
    setp(pump_pkg::P_PAUS, 1'b1);
    rd(pump_pkg::A_STAT);
    chk("src_pause", 32'h2, 32'(rv[6:4]));
    setp(pump_pkg::P_UP, 1'b1);
    setp(pump_pkg::P_DN, 1'b1);
    chk("rate_prime", 32'(pump_pkg::MAX_RATE), 32'(o_rate));
    rd(pump_pkg::A_STAT);
    chk("src_prime", 32'h1, 32'(rv[6:4]));
    @(posedge i_ref_clk) pins <= 10'h000;
    wr(pump_pkg::A_ASEL, 32'h4);
    setp(pump_pkg::P_STOP, 1'b1);
    setp(pump_pkg::P_STOP, 1'b0);
    rd(pump_pkg::A_STAT);
    chk("stopped", 32'h1, 32'(rv[0]));
    chk("alarm", 32'h1, 32'(o_alarm));
    setp(pump_pkg::P_STOP, 1'b1);
    setp(pump_pkg::P_STOP, 1'b0);
    rd(pump_pkg::A_STAT);
    chk("running", 32'h0, 32'(rv[0]));
  endtask : t_halt
  task automatic t_level();
    setp(pump_pkg::P_LV1, 1'b1);
    chk("warn", 32'h1, 32'(o_led_warn));
    setp(pump_pkg::P_LV2, 1'b1);
    chk("fault", 32'h1, 32'(o_led_fault));
    chk("err_show", 32'h1, 32'(o_err_show));
    chk("err_code", 32'(pump_pkg::E_LEVEL), 32'(o_err_code));
    setp(pump_pkg::P_UP, 1'b1);
    setp(pump_pkg::P_DN, 1'b1);
    rd(pump_pkg::A_STAT);
    chk("src_fault", 32'h2, 32'(rv[6:4]));
    @(posedge i_ref_clk) pins <= 10'h000;
    i_bus_state <= 2'h2;
    setp(pump_pkg::P_UP, 1'b0);
    chk("bus_red", 32'h1, 32'(o_led_bus_r));
    chk("lamp_off", 32'h0, 32'(o_led_fault));
  endtask : t_level
  task automatic t_modes();
    wr(pump_pkg::A_MRATE, 32'h0);
    wr(pump_pkg::A_FACTOR, 32'h64);
    wr(pump_pkg::A_CTRL, 32'h2);
    setp(pump_pkg::P_TRIG, 1'b1);
    setp(pump_pkg::P_TRIG, 1'b0);
    rd(pump_pkg::A_PEND);
    chk("pend_contact", 32'h64, rv);
    @(posedge i_ref_clk);
    i_rstn <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    wr(pump_pkg::A_BATCH, 32'h5);
    wr(pump_pkg::A_CTRL, 32'h3);
    setp(pump_pkg::P_PROG, 1'b1);
    setp(pump_pkg::P_PROG, 1'b0);
    rd(pump_pkg::A_PEND);
    chk("pend_batch", 32'h1f4, rv);
    wr(pump_pkg::A_CTRL, 32'h10);
    setp(pump_pkg::P_OVL, 1'b1);
    setp(pump_pkg::P_OVL, 1'b0);
    chk("ovl_code", 32'(pump_pkg::E_OVL), 32'(o_err_code));
    wr(pump_pkg::A_CTRL, 32'h1c5);
    i_analog <= pump_pkg::ANA_4MA;
    setp(pump_pkg::P_UP, 1'b0);
    chk("rate_4ma", 32'h0, 32'(o_rate));
    chk("iout_4ma", 32'(pump_pkg::IOUT_4MA), 32'(o_iout));
    @(posedge i_ref_clk) i_analog <= 10'h3ff;
    setp(pump_pkg::P_UP, 1'b0);
    chk("rate_full", 32'hc7, 32'(o_rate));
    chk("iout_full", 32'hfee, 32'(o_iout));
  endtask : t_modes
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  // hang guard well above the longest scenario
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {i_rstn, i_wr, i_rd, dry, i_addr, i_wdata, pins, i_analog, i_bus_state} = '0;
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_manual();
    t_stroke();
    t_halt();
    t_level();
    t_modes();
    close_out();
  end
endmodule : test_metering_pump_mode_arbiter
`default_nettype wire
